// ===== logic/rom_link_pkg.sv
// shared constants and types for the identity/command front end
// assumes a bit-level slot engine delivers sampled bits and command bytes
package rom_link_pkg;

  localparam int unsigned ID_BITS     = 64;
  localparam int unsigned FAMILY_BITS = 8;
  localparam int unsigned SERIAL_BITS = 48;
  localparam int unsigned BODY_BITS   = 56;
  localparam int unsigned CHECK_BITS  = 8;

  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h8c;   // x^8+x^5+x^4+1, reflected for lsb-first

  // identity-level command codes
  localparam logic [7:0] CMD_READ_ID     = 8'h33;
  localparam logic [7:0] CMD_MATCH_ID    = 8'h55;
  localparam logic [7:0] CMD_SEARCH_ID   = 8'hf0;
  localparam logic [7:0] CMD_COND_SEARCH = 8'hec;
  localparam logic [7:0] CMD_SKIP_ID     = 8'hcc;
  localparam logic [7:0] CMD_OD_SKIP     = 8'h3c;
  localparam logic [7:0] CMD_OD_MATCH    = 8'h69;
  localparam logic [7:0] CMD_RESUME      = 8'ha5;

  // linear address map
  localparam logic [15:0] SRAM_BASE   = 16'h0000;
  localparam logic [15:0] SRAM_END    = 16'h01ff;
  localparam logic [15:0] REGPG_BASE  = 16'h0200;
  localparam logic [15:0] REGPG_END   = 16'h023f;
  localparam logic [15:0] ROREG_BASE  = 16'h020c;
  localparam logic [15:0] ROREG_END   = 16'h020f;
  localparam logic [15:0] STAT_BASE   = 16'h0214;
  localparam logic [15:0] STAT_END    = 16'h0215;
  localparam logic [15:0] CNT_BASE    = 16'h021f;
  localparam logic [15:0] CNT_END     = 16'h022f;
  localparam logic [15:0] PWD_BASE    = 16'h0230;
  localparam logic [15:0] PWD_END     = 16'h023f;
  localparam logic [15:0] CAL_BASE    = 16'h0240;
  localparam logic [15:0] CAL_END     = 16'h027f;
  localparam logic [15:0] LOG_BASE    = 16'h1000;
  localparam logic [15:0] LOG_END     = 16'h2fff;

  typedef enum logic [3:0] {
    ID_NONE, ID_READ, ID_MATCH, ID_SEARCH, ID_COND, ID_SKIP, ID_ODSKIP, ID_ODMATCH, ID_RESUME
  } id_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_strobe_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
  } mem_req_t;

  typedef struct packed {
    logic ok;
    logic denied;
    logic mapped;
  } mem_ans_t;

endpackage

// ===== logic/crc8_serial.sv
// serial crc8 engine, one bit per bit_valid while ce is high
// assumes caller presents bits lsb first
`timescale 1ns/1ps
module crc8_serial
  import rom_link_pkg::*;
(
  // clock and control
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       clear,
  // bit stream
  input  wire logic       bit_valid,
  input  wire logic       bit_in,
  // result
  output logic [7:0] crc,
  output logic       zero
);

  logic       fb;
  logic [7:0] next_crc;

  assign fb       = crc[0] ^ bit_in;
  assign next_crc = (crc >> 1) ^ (fb ? CRC_POLY : CRC_INIT);

  always_ff @(posedge clk) begin
    if (srst) begin
      crc <= CRC_INIT;
    end else if (ce) begin
      if (clear) begin
        crc <= CRC_INIT;
      end else if (bit_valid) begin
        crc <= next_crc;
      end
    end
  end

  assign zero = (crc == CRC_INIT);

  property p_crc_step;
    @(posedge clk) disable iff (srst)
      (ce && !clear && bit_valid) |=> (crc == $past(next_crc));
  endproperty
  a_crc_step: assert property (p_crc_step) else $error("crc did not advance on bit");

  property p_crc_hold;
    @(posedge clk) disable iff (srst)
      (ce && !clear && !bit_valid) |=> $stable(crc);
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("crc moved without bit");

  property p_crc_clear;
    @(posedge clk) disable iff (srst)
      (ce && clear) |=> (crc == CRC_INIT);
  endproperty
  a_crc_clear: assert property (p_crc_clear) else $error("crc not cleared");

endmodule

// ===== logic/id_front_end.sv
// identity code, command hierarchy, speed switch and memory access guard
// assumes a slot engine supplies command bytes, id bit requests, and access requests; only bus_reset_pin sync'd here
// Operation
// - hold fixed 64-bit family, serial, check code
// - check value is crc8 x^8+x^5+x^4+1
// - crc starts zero, family lsb first
// - shifting check bits in gives zero
// - recognise all eight identity-level commands
// - overdrive command at standard speed enters overdrive
// - memory commands only after identity command
// - all bytes travel lsb first
// - memory except id and scratchpad linear
// - sram, register pages, calibration, logging regions
// - logging, counters, some registers read only
// - mission blocks writes to register pages
// - passwords writable, never readable
`timescale 1ns/1ps
module id_front_end
  import rom_link_pkg::*;
(
  // clock, reset, enable
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  // bus events from the slot engine (pin domain)
  input  wire logic         bus_reset_pin,
  input  wire byte_strobe_t cmd_byte,
  input  wire logic         id_cmd_done,
  input  wire logic         id_cmd_fail,
  // identity bit stream out, one bit per request
  input  wire logic         id_bit_req,
  output logic              id_bit,
  output logic              id_bit_valid,
  output logic              id_crc_ok,
  // mission state from the logging engine
  input  wire logic         mission_active,
  // memory access guard
  input  wire mem_req_t     mem_req,
  output mem_ans_t          mem_ans,
  // status
  output logic              overdrive,
  output logic              mem_cmds_open,
  output logic [3:0]        id_cmd_code
);

  // arbitrary family/serial values, fixed at build
  parameter logic [FAMILY_BITS-1:0] FAMILY_CODE = 8'h5a;
  parameter logic [SERIAL_BITS-1:0] SERIAL_NUM  = 48'h0123456789ab;

  // crc over body evaluated at elaboration so the stored code is self-consistent
  function automatic logic [7:0] crc_of(input logic [BODY_BITS-1:0] body);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 0; i < BODY_BITS; i++) begin
      c = (c >> 1) ^ ((c[0] ^ body[i]) ? CRC_POLY : CRC_INIT);
    end
    return c;
  endfunction

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  localparam logic [BODY_BITS-1:0] ID_BODY  = {SERIAL_NUM, FAMILY_CODE};
  localparam logic [ID_BITS-1:0]   ID_CODE  = {crc_of(ID_BODY), ID_BODY};

  // bus reset arrives from the pin side
  logic bus_rst_meta;
  logic bus_rst_sync;
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_rst_meta <= 1'b0;
      bus_rst_sync <= 1'b0;
    end else if (ce) begin
      bus_rst_meta <= bus_reset_pin;
      bus_rst_sync <= bus_rst_meta;
    end
  end

  typedef enum logic [1:0] {WAIT_ID, IN_ID, MEM_OPEN} phase_t;
  phase_t phase;
  phase_t next_phase;

  id_cmd_t decoded;
  logic    is_od_cmd;
  logic    cmd_known;

  assign decoded = (cmd_byte.data == CMD_READ_ID)     ? ID_READ    :
                   (cmd_byte.data == CMD_MATCH_ID)    ? ID_MATCH   :
                   (cmd_byte.data == CMD_SEARCH_ID)   ? ID_SEARCH  :
                   (cmd_byte.data == CMD_COND_SEARCH) ? ID_COND    :
                   (cmd_byte.data == CMD_SKIP_ID)     ? ID_SKIP    :
                   (cmd_byte.data == CMD_OD_SKIP)     ? ID_ODSKIP  :
                   (cmd_byte.data == CMD_OD_MATCH)    ? ID_ODMATCH :
                   (cmd_byte.data == CMD_RESUME)      ? ID_RESUME  : ID_NONE;
  assign cmd_known = (decoded != ID_NONE);
  assign is_od_cmd = (id_cmd_t'(id_cmd_code) == ID_ODSKIP) || (id_cmd_t'(id_cmd_code) == ID_ODMATCH);

  always_comb begin
    next_phase = phase;
    case (phase)
      WAIT_ID: begin
        if (cmd_byte.valid && cmd_known) begin
          next_phase = IN_ID;
        end
      end
      IN_ID: begin
        if (id_cmd_fail) begin
          next_phase = WAIT_ID;
        end else if (id_cmd_done) begin
          next_phase = MEM_OPEN;
        end
      end
      default: begin
        next_phase = MEM_OPEN;
      end
    endcase
    if (bus_rst_sync) begin
      next_phase = WAIT_ID;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      phase         <= WAIT_ID;
      id_cmd_code   <= 4'h0;
      mem_cmds_open <= 1'b0;
    end else if (ce) begin
      phase         <= next_phase;
      mem_cmds_open <= (next_phase == MEM_OPEN);
      if (phase == WAIT_ID && cmd_byte.valid && cmd_known) begin
        id_cmd_code <= 4'(decoded);
      end
    end
  end

  // overdrive holds once set; no bus_reset clears it, short or standard-length, so the
  // device keeps overdrive speed until srst returns it to standard speed
  always_ff @(posedge clk) begin
    if (srst) begin
      overdrive <= 1'b0;
    end else if (ce) begin
      if (phase == IN_ID && id_cmd_done && !id_cmd_fail && is_od_cmd && !overdrive) begin
        overdrive <= 1'b1;
      end
    end
  end

  // identity stream, lsb first, with running crc check
  logic [5:0] bit_idx;
  logic       crc_clear;
  logic       cur_bit;
  logic [7:0] crc_val;
  logic       crc_zero;

  assign cur_bit   = ID_CODE[bit_idx];
  assign crc_clear = bus_rst_sync;

  always_ff @(posedge clk) begin
    if (srst) begin
      bit_idx      <= 6'h00;
      id_bit       <= 1'b0;
      id_bit_valid <= 1'b0;
      id_crc_ok    <= 1'b0;
    end else if (ce) begin
      id_bit_valid <= id_bit_req && !bus_rst_sync;
      if (bus_rst_sync) begin
        bit_idx <= 6'h00;
      end else if (id_bit_req) begin
        id_bit  <= cur_bit;
        bit_idx <= bit_idx + 6'h01;
      end
      id_crc_ok <= crc_zero;
    end
  end

  crc8_serial u_crc (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .clear     (crc_clear),
    .bit_valid (id_bit_req && !bus_rst_sync),
    .bit_in    (cur_bit),
    .crc       (crc_val),
    .zero      (crc_zero)
  );

  // access guard over the linear map
  logic a_sram, a_reg, a_cal, a_log, a_ro, a_pwd, mapped, deny;
  assign a_sram = in_range(mem_req.addr, SRAM_BASE, SRAM_END);
  assign a_reg  = in_range(mem_req.addr, REGPG_BASE, REGPG_END);
  assign a_cal  = in_range(mem_req.addr, CAL_BASE, CAL_END);
  assign a_log  = in_range(mem_req.addr, LOG_BASE, LOG_END);
  assign a_ro   = a_log || in_range(mem_req.addr, ROREG_BASE, ROREG_END) ||
                  in_range(mem_req.addr, STAT_BASE, STAT_END) || in_range(mem_req.addr, CNT_BASE, CNT_END);
  assign a_pwd  = in_range(mem_req.addr, PWD_BASE, PWD_END);
  assign mapped = a_sram || a_reg || a_cal || a_log;
  assign deny   = !mem_cmds_open || !mapped ||
                  (mem_req.write && a_ro) ||
                  (mem_req.write && a_reg && mission_active) ||
                  (!mem_req.write && a_pwd);

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_ans <= '0;
    end else if (ce) begin
      mem_ans.ok     <= mem_req.valid && !deny;
      mem_ans.denied <= mem_req.valid && deny;
      mem_ans.mapped <= mem_req.valid && mapped;
    end
  end

  property p_ro_write;
    @(posedge clk) disable iff (srst)
      (ce && mem_req.valid && mem_req.write && a_log) |=> (mem_ans.denied && !mem_ans.ok);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("write to log memory accepted");

  property p_mission_lock;
    @(posedge clk) disable iff (srst)
      (ce && mem_req.valid && mem_req.write && a_reg && mission_active) |=> mem_ans.denied;
  endproperty
  a_mission_lock: assert property (p_mission_lock) else $error("register write during mission");

  property p_pwd_read;
    @(posedge clk) disable iff (srst)
      (ce && mem_req.valid && !mem_req.write && a_pwd) |=> !mem_ans.ok;
  endproperty
  a_pwd_read: assert property (p_pwd_read) else $error("password read back");

  property p_pwd_write;
    @(posedge clk) disable iff (srst)
      (ce && mem_cmds_open && mem_req.valid && mem_req.write && a_pwd && !mission_active) |=> mem_ans.ok;
  endproperty
  a_pwd_write: assert property (p_pwd_write) else $error("password write refused");

  property p_gate;
    @(posedge clk) disable iff (srst)
      mem_ans.ok |-> $past(mem_cmds_open);
  endproperty
  a_gate: assert property (p_gate) else $error("memory access before identity command");

  sequence s_od_done;
    ce && phase == IN_ID && id_cmd_done && !id_cmd_fail && is_od_cmd && !overdrive;
  endsequence
  property p_overdrive;
    @(posedge clk) disable iff (srst)
      s_od_done |=> overdrive;
  endproperty
  a_overdrive: assert property (p_overdrive) else $error("overdrive not entered");

  property p_decode;
    @(posedge clk) disable iff (srst)
      (ce && phase == WAIT_ID && cmd_byte.valid && cmd_byte.data == CMD_RESUME) |=>
        (id_cmd_t'(id_cmd_code) == ID_RESUME);
  endproperty
  a_decode: assert property (p_decode) else $error("resume not recognised");

  property p_id_lsb;
    @(posedge clk) disable iff (srst)
      (ce && id_bit_req && !bus_rst_sync && bit_idx == 6'h00) |=> (id_bit == FAMILY_CODE[0]);
  endproperty
  a_id_lsb: assert property (p_id_lsb) else $error("first id bit not family lsb");

endmodule

// ===== tb/bus_master_model.sv
// master-side model of the single-wire bus controller facing id_front_end
// assumes the bench calls its tasks 2 ns after a rising clk; every task ends likewise
`timescale 1ns/1ps
module bus_master_model
  import rom_link_pkg::*;
(
  // clock
  input  wire logic    clk,
  // requests towards the device
  output byte_strobe_t cmd_byte,
  output logic         bus_reset_pin,
  output logic         id_cmd_done,
  output logic         id_cmd_fail,
  output logic         id_bit_req,
  // identity stream back
  input  wire logic    id_bit,
  input  wire logic    id_bit_valid
);
  logic [7:0] rx_crc;

  initial begin
    cmd_byte = '0;
    bus_reset_pin = 1'b0;
    id_cmd_done = 1'b0;
    id_cmd_fail = 1'b0;
    id_bit_req = 1'b0;
    rx_crc = 8'h00;
  end

  // receiver check: crc over every bit incl. check bits, lsb first, x^8+x^5+x^4+1 reflected
  always @(posedge clk) begin
    if (id_bit_valid === 1'b1) begin
      rx_crc = (rx_crc >> 1) ^ ((rx_crc[0] ^ id_bit) ? 8'h8c : 8'h00);
    end
  end

  task automatic bus_reset();
    bus_reset_pin = 1'b1;
    repeat (3) @(posedge clk);
    #2 bus_reset_pin = 1'b0;
    rx_crc = 8'h00;
    repeat (3) @(posedge clk);
    #2;
  endtask

  // released byte lines show the inverse, so a stale value cannot pass
  task automatic send_cmd(logic [7:0] b);
    cmd_byte = '{valid: 1'b1, data: b};
    @(posedge clk);
    #2 cmd_byte = '{valid: 1'b0, data: ~b};
  endtask

  task automatic end_cmd(logic fail);
    id_cmd_done = !fail;
    id_cmd_fail = fail;
    @(posedge clk);
    #2 id_cmd_done = 1'b0;
    id_cmd_fail = 1'b0;
  endtask

  // extra edges let the last registered bit land before the caller looks
  task automatic req_bits(int n);
    id_bit_req = 1'b1;
    repeat (n) @(posedge clk);
    #2 id_bit_req = 1'b0;
    repeat (2) @(posedge clk);
    #2;
  endtask
endmodule

// ===== tb/single_wire_rom_crc_test.sv
// self-checking bench for id_front_end
// assumes bus_master_model drives the bus-side inputs; ce stays high except during the frozen bus reset
`timescale 1ns/1ps
module single_wire_rom_crc_test;
  import rom_link_pkg::*;
  localparam logic [7:0]  FAM = 8'h3e;            // arbitrary family value
  localparam logic [47:0] SER = 48'h00a1b2c3d4e5; // arbitrary serial value
  localparam logic [7:0]  CMDS [8] = '{CMD_READ_ID, CMD_MATCH_ID, CMD_SEARCH_ID, CMD_COND_SEARCH,
                                       CMD_SKIP_ID, CMD_OD_SKIP, CMD_OD_MATCH, CMD_RESUME};
  localparam logic [15:0] PTS [15] = '{SRAM_BASE, SRAM_END, REGPG_BASE, ROREG_BASE, ROREG_END,
                                       STAT_BASE, STAT_END, CNT_BASE, CNT_END, PWD_BASE, PWD_END,
                                       CAL_BASE, CAL_END, LOG_BASE, LOG_END};
  logic         clk, srst, ce, mission_active, id_bit, id_bit_valid, id_crc_ok, overdrive;
  logic         mem_cmds_open, bus_reset_pin, id_cmd_done, id_cmd_fail, id_bit_req;
  logic [3:0]   id_cmd_code;
  byte_strobe_t cmd_byte;
  mem_req_t     mem_req;
  mem_ans_t     mem_ans;
  mem_ans_t     ans_q [$];
  logic         bit_q [$];
  logic [63:0]  code;
  logic [15:0]  a;
  int           n_fail, num_checks;

  id_front_end #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER)) i_dut (.clk(clk), .srst(srst), .ce(ce),
    .bus_reset_pin(bus_reset_pin), .cmd_byte(cmd_byte), .id_cmd_done(id_cmd_done),
    .id_cmd_fail(id_cmd_fail), .id_bit_req(id_bit_req), .id_bit(id_bit), .id_bit_valid(id_bit_valid),
    .id_crc_ok(id_crc_ok), .mission_active(mission_active), .mem_req(mem_req), .mem_ans(mem_ans),
    .overdrive(overdrive), .mem_cmds_open(mem_cmds_open), .id_cmd_code(id_cmd_code));

  bus_master_model i_master (.clk(clk), .cmd_byte(cmd_byte), .bus_reset_pin(bus_reset_pin),
    .id_cmd_done(id_cmd_done), .id_cmd_fail(id_cmd_fail), .id_bit_req(id_bit_req), .id_bit(id_bit),
    .id_bit_valid(id_bit_valid));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic fail_msg(string m);
    n_fail++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic cmp_ans(mem_ans_t got, mem_ans_t exp);
    num_checks++;
    if (got !== exp) fail_msg($sformatf("answer %b want %b", got, exp));
  endtask

  task automatic cmp_bit(logic got, logic exp);
    num_checks++;
    if (got !== exp) fail_msg($sformatf("id bit %b want %b", got, exp));
  endtask

  task automatic cmp_val(logic [7:0] got, logic [7:0] exp, string what);
    num_checks++;
    if (got !== exp) fail_msg($sformatf("%s %h want %h", what, got, exp));
  endtask

  function automatic logic inr(logic [15:0] x, logic [15:0] lo, logic [15:0] hi);
    return x >= lo && x <= hi;
  endfunction

  function automatic mem_ans_t exp_ans(logic [15:0] x, logic w, logic m, logic open);
    logic rg, ro, map, den;
    rg = inr(x, REGPG_BASE, REGPG_END);
    ro = inr(x, LOG_BASE, LOG_END) || inr(x, ROREG_BASE, ROREG_END) || inr(x, STAT_BASE, STAT_END)
         || inr(x, CNT_BASE, CNT_END);
    map = inr(x, SRAM_BASE, SRAM_END) || rg || inr(x, CAL_BASE, CAL_END) || inr(x, LOG_BASE, LOG_END);
    den = !open || !map || (w && ro) || (w && rg && m) || (!w && inr(x, PWD_BASE, PWD_END));
    return '{ok: !den, denied: den, mapped: map};
  endfunction

  function automatic logic [63:0] id_code();
    logic [55:0] body;
    logic [7:0]  c;
    body = {SER, FAM};
    c = 8'h00;
    for (int i = 0; i < 56; i++) c = (c >> 1) ^ ((c[0] ^ body[i]) ? 8'h8c : 8'h00);
    return {c, body};
  endfunction

  // held across calls so back-to-back requests never re-assign in one step
  task automatic access(logic [15:0] x, logic w, logic m, logic open);
    mission_active = m;
    mem_req = '{valid: 1'b1, write: w, addr: x};
    ans_q.push_back(exp_ans(x, w, m, open));
    @(posedge clk);
    #2;
  endtask

  task automatic idle();
    mem_req = '{valid: 1'b0, write: 1'b0, addr: ~mem_req.addr};
    @(posedge clk);
    #2;
  endtask

  always @(negedge clk) begin
    if (mem_ans.ok === 1'b1 || mem_ans.denied === 1'b1) begin
      if (ans_q.size() == 0) fail_msg("unexpected answer");
      else cmp_ans(mem_ans, ans_q.pop_front());
    end
    if (id_bit_valid === 1'b1) begin
      if (bit_q.size() == 0) fail_msg("unexpected id bit");
      else cmp_bit(id_bit, bit_q.pop_front());
    end
  end

  task automatic give_verdict();
    for (int t = 0; t < 10 && (ans_q.size() != 0 || bit_q.size() != 0); t++) @(posedge clk);
    if (ans_q.size() != 0 || bit_q.size() != 0) fail_msg("results missing");
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    n_fail = 0;
    num_checks = 0;
    srst = 1'b1;
    ce = 1'b1;
    mission_active = 1'b0;
    mem_req = '0;
    void'($urandom(41564));
    code = id_code();
    repeat (16) @(posedge clk);
    #2 srst = 1'b0;
    i_master.bus_reset();
    i_master.send_cmd(8'h00);
    i_master.end_cmd(1'b0);
    @(posedge clk);
    #2 cmp_val(8'(id_cmd_code), 8'h00, "unknown command");
    cmp_val(8'(mem_cmds_open), 8'h00, "open after unknown");
    access(SRAM_BASE, 1'b0, 1'b0, 1'b0);
    access(CAL_BASE, 1'b1, 1'b0, 1'b0);
    idle();
    $display("test gate closed done");
    for (int i = 0; i < 8; i++) begin
      i_master.bus_reset();
      cmp_val(8'(mem_cmds_open), 8'h00, "open after bus reset");
      i_master.send_cmd(CMDS[i]);
      cmp_val(8'(id_cmd_code), 8'(i + 1), "command");
      if (i == 0) begin
        for (int k = 0; k < 64; k++) bit_q.push_back(code[k]);
        i_master.req_bits(56);
        cmp_val(i_master.rx_crc, code[63:56], "crc of body");
        cmp_val(8'(id_crc_ok), 8'(code[63:56] == 8'h00), "crc ok mid");
        i_master.req_bits(8);
        cmp_val(i_master.rx_crc, 8'h00, "crc of code");
        cmp_val(8'(id_crc_ok), 8'h01, "crc ok end");
      end
      i_master.end_cmd(i == 2);
      @(posedge clk);
      #2 cmp_val(8'(mem_cmds_open), 8'(i != 2), "open");
      cmp_val(8'(overdrive), 8'(i >= 5), "overdrive");
    end
    $display("test commands done");
    for (int k = 0; k < 400; k++) begin
      a = PTS[$urandom_range(14, 0)] + 16'($urandom_range(2, 0)) - 16'h0001;
      access(a, 1'($urandom), 1'($urandom), 1'b1);
    end
    idle();
    $display("test memory map done");
    // a bus reset while frozen must not reach the synchroniser
    ce = 1'b0;
    i_master.bus_reset();
    ce = 1'b1;
    cmp_val(8'(mem_cmds_open), 8'h01, "open while frozen");
    cmp_val(8'(overdrive), 8'h01, "overdrive while frozen");
    $display("test clock enable done");
    srst = 1'b1;
    @(posedge clk);
    #2 srst = 1'b0;
    cmp_val(8'(overdrive), 8'h00, "overdrive after reset");
    cmp_val(8'(mem_cmds_open), 8'h00, "open after reset");
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
